/* File: hdl/cptr_pkg.sv */
// constants for the charger path, dither and thermal register bank
`default_nettype none
package cptr_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] CPTR_OFS_PWR_PATH = 8'h19;
	localparam logic [7:0] CPTR_OFS_DITHER   = 8'h1a;
	localparam logic [7:0] CPTR_OFS_THERMAL  = 8'h1b;
	// ==========================================================
	// power path field positions
	localparam int CPTR_PP_RESTORE_BIT  = 7;
	localparam int CPTR_PP_LOAD_BIT     = 6;
	localparam int CPTR_PP_PFM_BIT      = 5;
	localparam int CPTR_PP_AUTO_REV_BIT = 1;
	localparam int CPTR_PP_REV_BIT      = 0;
	// ==========================================================
	// dither field positions
	localparam int CPTR_DI_FIELD_LSB = 3;
	localparam int CPTR_DI_RSV_LSB   = 5;
	// ==========================================================
	// thermal field positions
	localparam int CPTR_TH_HOT_LSB  = 6;
	localparam int CPTR_TH_WARM_LSB = 4;
	localparam int CPTR_TH_COOL_LSB = 2;
	localparam int CPTR_TH_COLD_LSB = 0;
	// ==========================================================
	// reset values
	localparam logic [7:0] CPTR_RST_PWR_PATH = 8'h00;
	localparam logic [7:0] CPTR_RST_DITHER   = 8'h20;
	localparam logic [7:0] CPTR_RST_THERMAL  = 8'h96;
	localparam logic [2:0] CPTR_DI_RSV_VAL   = 3'h1;
	localparam logic [1:0] CPTR_DITHER_OFF   = 2'h0;
	localparam logic [1:0] CPTR_HOT_RST      = 2'h2;
	localparam logic [1:0] CPTR_WARM_RST     = 2'h1;
	localparam logic [1:0] CPTR_COOL_RST     = 2'h1;
	localparam logic [1:0] CPTR_COLD_RST     = 2'h2;
endpackage
`default_nettype wire

/* File: hdl/cptr_regs.sv */
// power path, frequency spread and thermistor threshold registers
`timescale 1ns/1ps
`default_nettype none
module cptr_regs (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// register port from the serial host interface
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// device events
	input  wire logic       watchdog_expired_i,
	input  wire logic       adapter_plugin_i,
	input  wire logic       sync_valid_detect_i,
	input  wire logic       battery_below_target_i,
	input  wire logic       watchdog_restart_req_i,
	input  wire logic       watchdog_restarted_i,
	// control outputs
	output logic            register_restore_o,
	output logic            input_load_sink_enable_o,
	output logic            light_load_pulse_skip_enable_o,
	output logic            automatic_discharge_enable_o,
	output logic            discharge_direction_enable_o,
	output logic            reverse_mode_active_o,
	output logic      [1:0] dither_level_o,
	output logic      [1:0] hot_limit_select_o,
	output logic      [1:0] warm_limit_select_o,
	output logic      [1:0] cool_limit_select_o,
	output logic      [1:0] cold_limit_select_o,
	output logic            watchdog_restart_bit_o
);
	// ==========================================================
	// state
	typedef struct packed {
		logic       load_en;
		logic       pfm_en;
		logic       auto_rev;
		logic       rev_en;
		logic [1:0] dither;
		logic [7:0] thermal;
		logic [7:0] rdata;
		logic       restore;
		logic       rev_active;
		logic       wd_restart;
	} cptr_state_t;

	cptr_state_t st_r;
	cptr_state_t st_nxt;

	logic       wr_pp;
	logic       wr_di;
	logic       wr_th;
	logic       restore_req;
	logic [7:0] pp_view;
	logic [7:0] di_view;

	assign wr_pp       = reg_wr_i && (reg_addr_i == cptr_pkg::CPTR_OFS_PWR_PATH);
	assign wr_di       = reg_wr_i && (reg_addr_i == cptr_pkg::CPTR_OFS_DITHER);
	assign wr_th       = reg_wr_i && (reg_addr_i == cptr_pkg::CPTR_OFS_THERMAL);
	assign restore_req = wr_pp && reg_wdata_i[cptr_pkg::CPTR_PP_RESTORE_BIT];

	// ==========================================================
	// read views, reserved bits fixed
	always_comb begin
		pp_view = cptr_pkg::CPTR_RST_PWR_PATH;
		pp_view[cptr_pkg::CPTR_PP_LOAD_BIT]     = st_r.load_en;
		pp_view[cptr_pkg::CPTR_PP_PFM_BIT]      = st_r.pfm_en;
		pp_view[cptr_pkg::CPTR_PP_AUTO_REV_BIT] = st_r.auto_rev;
		pp_view[cptr_pkg::CPTR_PP_REV_BIT]      = st_r.rev_en;
		di_view = cptr_pkg::CPTR_RST_DITHER;
		di_view[cptr_pkg::CPTR_DI_FIELD_LSB +: 2] = st_r.dither;
	end

	// ==========================================================
	// next state
	always_comb begin
		st_nxt         = st_r;
		st_nxt.restore = 1'b0;
		if (wr_pp) begin
			st_nxt.load_en  = reg_wdata_i[cptr_pkg::CPTR_PP_LOAD_BIT];
			st_nxt.pfm_en   = reg_wdata_i[cptr_pkg::CPTR_PP_PFM_BIT];
			st_nxt.auto_rev = reg_wdata_i[cptr_pkg::CPTR_PP_AUTO_REV_BIT];
			st_nxt.rev_en   = reg_wdata_i[cptr_pkg::CPTR_PP_REV_BIT];
		end
		if (wr_di) begin
			st_nxt.dither = reg_wdata_i[cptr_pkg::CPTR_DI_FIELD_LSB +: 2];
		end
		if (wr_th) begin
			st_nxt.thermal = reg_wdata_i;
		end
		// sync clears pulse skipping unless the host writes one now
		if (sync_valid_detect_i && !(wr_pp && reg_wdata_i[cptr_pkg::CPTR_PP_PFM_BIT])) begin
			st_nxt.pfm_en = 1'b0;
		end
		if (watchdog_expired_i) begin
			st_nxt.load_en  = 1'b0;
			st_nxt.auto_rev = 1'b0;
			st_nxt.rev_en   = 1'b0;
		end
		if (adapter_plugin_i) begin
			st_nxt.rev_en = 1'b0;
		end
		// restart request wins over the done strobe
		if (watchdog_restarted_i) begin
			st_nxt.wd_restart = 1'b0;
		end
		if (watchdog_restart_req_i) begin
			st_nxt.wd_restart = 1'b1;
		end
		if (restore_req) begin
			st_nxt.load_en    = cptr_pkg::CPTR_RST_PWR_PATH[cptr_pkg::CPTR_PP_LOAD_BIT];
			st_nxt.pfm_en     = cptr_pkg::CPTR_RST_PWR_PATH[cptr_pkg::CPTR_PP_PFM_BIT];
			st_nxt.auto_rev   = cptr_pkg::CPTR_RST_PWR_PATH[cptr_pkg::CPTR_PP_AUTO_REV_BIT];
			st_nxt.rev_en     = cptr_pkg::CPTR_RST_PWR_PATH[cptr_pkg::CPTR_PP_REV_BIT];
			st_nxt.dither     = cptr_pkg::CPTR_DITHER_OFF;
			st_nxt.thermal    = cptr_pkg::CPTR_RST_THERMAL;
			st_nxt.wd_restart = 1'b0;
			st_nxt.restore    = 1'b1;
		end
		st_nxt.rev_active = st_nxt.rev_en || (st_nxt.auto_rev && battery_below_target_i);
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				cptr_pkg::CPTR_OFS_PWR_PATH: st_nxt.rdata = pp_view;
				cptr_pkg::CPTR_OFS_DITHER:   st_nxt.rdata = di_view;
				cptr_pkg::CPTR_OFS_THERMAL:  st_nxt.rdata = st_r.thermal;
				default:                     st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_r.load_en    <= 1'b0;
			st_r.pfm_en     <= 1'b0;
			st_r.auto_rev   <= 1'b0;
			st_r.rev_en     <= 1'b0;
			st_r.dither     <= cptr_pkg::CPTR_DITHER_OFF;
			st_r.thermal    <= cptr_pkg::CPTR_RST_THERMAL;
			st_r.rdata      <= 8'h00;
			st_r.restore    <= 1'b0;
			st_r.rev_active <= 1'b0;
			st_r.wd_restart <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o                    = st_r.rdata;
	assign register_restore_o             = st_r.restore;
	assign input_load_sink_enable_o       = st_r.load_en;
	assign light_load_pulse_skip_enable_o = st_r.pfm_en;
	assign automatic_discharge_enable_o   = st_r.auto_rev;
	assign discharge_direction_enable_o   = st_r.rev_en;
	assign reverse_mode_active_o          = st_r.rev_active;
	assign dither_level_o                 = st_r.dither;
	assign hot_limit_select_o             = st_r.thermal[cptr_pkg::CPTR_TH_HOT_LSB +: 2];
	assign warm_limit_select_o            = st_r.thermal[cptr_pkg::CPTR_TH_WARM_LSB +: 2];
	assign cool_limit_select_o            = st_r.thermal[cptr_pkg::CPTR_TH_COOL_LSB +: 2];
	assign cold_limit_select_o            = st_r.thermal[cptr_pkg::CPTR_TH_COLD_LSB +: 2];
	assign watchdog_restart_bit_o         = st_r.wd_restart;

	// ==========================================================
	// checks
	a_reset_defaults: assert property (@(posedge clk_i)
		!rst_b_i |=> {hot_limit_select_o, warm_limit_select_o, cool_limit_select_o,
			cold_limit_select_o} == {cptr_pkg::CPTR_HOT_RST, cptr_pkg::CPTR_WARM_RST,
			cptr_pkg::CPTR_COOL_RST, cptr_pkg::CPTR_COLD_RST}
			&& !light_load_pulse_skip_enable_o && !discharge_direction_enable_o)
		else $error("reset did not restore defaults");
	a_restore_defaults: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		restore_req |=> (st_r.thermal == cptr_pkg::CPTR_RST_THERMAL)
			&& (st_r.dither == cptr_pkg::CPTR_DITHER_OFF)
			&& !st_r.load_en && !st_r.rev_en && register_restore_o)
		else $error("restore did not return defaults");
	a_restore_reads_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_rd_i && (reg_addr_i == cptr_pkg::CPTR_OFS_PWR_PATH)
		|=> !reg_rdata_o[cptr_pkg::CPTR_PP_RESTORE_BIT] && (reg_rdata_o[4:2] == 3'h0))
		else $error("restore or reserved bit read back one");
	a_wdog_clears_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		watchdog_expired_i |=> !input_load_sink_enable_o && !automatic_discharge_enable_o
			&& !discharge_direction_enable_o)
		else $error("watchdog left load or discharge set");
	a_load_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wr_pp && !restore_req && !watchdog_expired_i
		|=> input_load_sink_enable_o == 1'($past(reg_wdata_i) >> cptr_pkg::CPTR_PP_LOAD_BIT))
		else $error("host write of load sink lost");
	a_sync_clears_pfm: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		sync_valid_detect_i && !(wr_pp && reg_wdata_i[cptr_pkg::CPTR_PP_PFM_BIT])
		|=> !light_load_pulse_skip_enable_o)
		else $error("sync did not clear pulse skip");
	a_force_pfm: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wr_pp && reg_wdata_i[cptr_pkg::CPTR_PP_PFM_BIT] && !restore_req
		|=> light_load_pulse_skip_enable_o)
		else $error("host write of pulse skip lost");
	a_plugin_clears_rev: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		adapter_plugin_i |=> !discharge_direction_enable_o)
		else $error("adapter plug-in left discharge enabled");
	a_manual_reverse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		discharge_direction_enable_o |-> reverse_mode_active_o)
		else $error("manual discharge did not engage reverse");
	a_auto_reverse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		automatic_discharge_enable_o && battery_below_target_i
		&& !watchdog_expired_i && !restore_req && !wr_pp |=> reverse_mode_active_o)
		else $error("auto reverse did not engage");
	a_dither_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wr_di |=> dither_level_o == 2'($past(reg_wdata_i) >> cptr_pkg::CPTR_DI_FIELD_LSB))
		else $error("dither write not stored");
	a_dither_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_rd_i && (reg_addr_i == cptr_pkg::CPTR_OFS_DITHER)
		|=> reg_rdata_o == {cptr_pkg::CPTR_DI_RSV_VAL, $past(dither_level_o), 3'h0})
		else $error("dither register read wrong");
	a_thermal_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wr_th
		|=> {hot_limit_select_o, warm_limit_select_o, cool_limit_select_o,
			cold_limit_select_o} == $past(reg_wdata_i))
		else $error("thermal limits not stored");
	a_restart_held: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		watchdog_restart_req_i |=> watchdog_restart_bit_o || $past(restore_req))
		else $error("restart request lost");
	a_restart_done: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		watchdog_restarted_i && !watchdog_restart_req_i |=> !watchdog_restart_bit_o)
		else $error("restart bit not cleared after restart");
endmodule // cptr_regs
`default_nettype wire

/* File: tb/cptr_host.sv */
// host model driving the register port of the bank
`timescale 1ns/1ps
`default_nettype none
module cptr_host (
	// clock and read data
	input  wire logic       clk_i,
	input  wire logic [7:0] reg_rdata_i,
	// register port
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic            restart_req_o
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		restart_req_o = 1'b0;
	end
	// released data is inverted so stale values never pass
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge clk_i);
		reg_wr_o <= 1'b0;
		reg_wdata_o <= ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge clk_i);
		reg_rd_o <= 1'b0;
		#1 d = reg_rdata_i;
	endtask
	task automatic restart;
		@(posedge clk_i);
		restart_req_o <= 1'b1;
		@(posedge clk_i);
		restart_req_o <= 1'b0;
	endtask
	// clears both discharge enables, pulse skipping left off
	task automatic leave_reverse;
		wr_reg(cptr_pkg::CPTR_OFS_PWR_PATH, 8'h00);
	endtask
endmodule // cptr_host
`default_nettype wire

/* File: tb/tb_charger_path_dither_thermal_regs.sv */
// self-checking bench for the charger register bank
`timescale 1ns/1ps
`default_nettype none
module tb_charger_path_dither_thermal_regs;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [3:0] ev = 4'h0;
	logic bat = 1'b0;
	int n_errors = 0;
	int checked = 0;
	wire logic [7:0] addr, wdata, rdata, lim;
	wire logic wr, rd, rreq, rst_pls, rev, wdb;
	wire logic load, pfm, arev, drev;
	wire logic [1:0] dith;
	wire logic [7:0] pp_pins = {1'b0, load, pfm, 3'h0, arev, drev};
	wire logic [7:0] di_pins = {3'h1, dith, 3'h0};
	logic [7:0] row [9][3] = '{'{8'h1b, 8'h5a, 8'h5a}, '{8'h1b, 8'hff, 8'hff},
		'{8'h1b, 8'h00, 8'h00}, '{8'h1a, 8'hff, 8'h38}, '{8'h1a, 8'h08, 8'h28},
		'{8'h1a, 8'h10, 8'h30}, '{8'h19, 8'h7f, 8'h63}, '{8'h19, 8'h00, 8'h00},
		'{8'h30, 8'hff, 8'h00}};
	always #5 clk_i = ~clk_i;
	cptr_host host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wdata_o(wdata),
		.reg_wr_o(wr), .reg_rd_o(rd), .restart_req_o(rreq));
	cptr_regs DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .watchdog_expired_i(ev[0]),
		.adapter_plugin_i(ev[1]), .sync_valid_detect_i(ev[2]), .battery_below_target_i(bat),
		.watchdog_restart_req_i(rreq), .watchdog_restarted_i(ev[3]),
		.register_restore_o(rst_pls), .input_load_sink_enable_o(load),
		.light_load_pulse_skip_enable_o(pfm), .automatic_discharge_enable_o(arev),
		.discharge_direction_enable_o(drev), .reverse_mode_active_o(rev), .dither_level_o(dith),
		.hot_limit_select_o(lim[7:6]), .warm_limit_select_o(lim[5:4]),
		.cool_limit_select_o(lim[3:2]), .cold_limit_select_o(lim[1:0]),
		.watchdog_restart_bit_o(wdb));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd_reg(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask
	task automatic pulse(input int k);
		@(posedge clk_i);
		ev[k] <= 1'b1;
		@(posedge clk_i);
		ev <= 4'h0;
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		#1 chk("limits", 8'h96, lim);
		rdc(8'h19, 8'h00);
		rdc(8'h1a, 8'h20);
		rdc(8'h1b, 8'h96);
		for (int i = 0; i < 9; i++) begin
			host.wr_reg(row[i][0], row[i][1]);
			rdc(row[i][0], row[i][2]);
			if (row[i][0] == 8'h19)
				chk("power path pins", row[i][2], pp_pins);
			else if (row[i][0] == 8'h1a)
				chk("dither pins", row[i][2], di_pins);
			else if (row[i][0] == 8'h1b)
				chk("limit pins", row[i][2], lim);
		end
		host.wr_reg(8'h1b, 8'h00);
		host.wr_reg(8'h1a, 8'h18);
		host.wr_reg(8'h19, 8'hff);
		#1 chk("restore", 8'h01, {7'h00, rst_pls});
		chk("restored power pins", 8'h00, pp_pins);
		chk("restored dither pins", 8'h20, di_pins);
		rdc(8'h19, 8'h00);
		rdc(8'h1a, 8'h20);
		rdc(8'h1b, 8'h96);
		host.wr_reg(8'h19, 8'h63);
		pulse(0);
		rdc(8'h19, 8'h20);
		host.wr_reg(8'h19, 8'h63);
		pulse(1);
		rdc(8'h19, 8'h62);
		pulse(2);
		rdc(8'h19, 8'h42);
		fork
			host.wr_reg(8'h19, 8'h63);
			pulse(2);
		join
		rdc(8'h19, 8'h63);
		host.leave_reverse();
		host.wr_reg(8'h19, 8'h02);
		bat <= 1'b1;
		@(posedge clk_i);
		#1 chk("reverse on", 8'h01, {7'h00, rev});
		@(posedge clk_i);
		bat <= 1'b0;
		@(posedge clk_i);
		#1 chk("reverse off", 8'h00, {7'h00, rev});
		host.restart();
		#1 chk("restart set", 8'h01, {7'h00, wdb});
		pulse(3);
		#1 chk("restart done", 8'h00, {7'h00, wdb});
		// mid-run reset returns every field to its default
		host.wr_reg(8'h1b, 8'h00);
		host.wr_reg(8'h19, 8'h63);
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		#1 chk("reset limits", 8'h96, lim);
		chk("reset power pins", 8'h00, pp_pins);
		rdc(8'h19, 8'h00);
		rdc(8'h1b, 8'h96);
		stop_test();
	end
	initial begin
		#20000;
		n_errors++;
		stop_test();
	end
endmodule // tb_charger_path_dither_thermal_regs
`default_nettype wire
